// File: logic/dprpc_pkg.sv
// constants, field layout and counter operation codes for the port control block
// assumes one port clock mclk at 125 MHz and a classic wishbone register bus
package dprpc_pkg;
   // ************************************
   // widths and memory size
   // ************************************
   localparam int          CNT_W     = 8;
   localparam int          DATA_W    = 16;
   localparam int          MEM_DEPTH = 256;
   localparam int          WB_AW     = 8;
   localparam int          IRQ_W     = 3;
   // ************************************
   // register offsets (byte addresses)
   // ************************************
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_IRQ_STAT = 8'h08;
   localparam logic [7:0]  REG_IRQ_CLR  = 8'h0C;
   localparam logic [7:0]  REG_IRQ_EN   = 8'h10;
   // ************************************
   // field positions and reset values
   // ************************************
   localparam int          CTRL_DLL_OFF  = 0;
   localparam int          ST_READY      = 0;
   localparam int          ST_DLL_LOCK   = 1;
   localparam int          ST_ZQ_DONE    = 2;
   localparam int          ST_PIPE       = 3;
   localparam int          ST_DLL_ON     = 4;
   localparam int          ST_CNT_LSB    = 8;
   localparam int          IRQ_CNT       = 0;
   localparam int          IRQ_READY     = 1;
   localparam int          IRQ_WRAP      = 2;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [2:0]  IRQ_EN_RST    = 3'h0;
   localparam logic [7:0]  MASK_RST      = 8'hFF;
   // ************************************
   // timing
   // ************************************
   localparam int          CLK_MHZ          = 125;
   localparam int          DLL_LOCK_CLOCKS  = 1024;
   localparam int          ZQ_CAL_TIME_NS   = 512;
   localparam int          ZQ_CAL_CYCLES    = (ZQ_CAL_TIME_NS * CLK_MHZ + 999) / 1000;
   // ************************************
   // counter operations, one-hot
   // ************************************
   typedef enum logic [4:0] {
      OP_HOLD  = 5'b0_0001,
      OP_RESET = 5'b0_0010,
      OP_LOAD  = 5'b0_0100,
      OP_RETX  = 5'b0_1000,
      OP_INC   = 5'b1_0000
   } dprpc_cnt_op_t;
endpackage

// File: logic/dprpc_port.sv
// one memory port: array access, burst counter, dll and impedance calibration,
// echo clock, wishbone register file with interrupt
// assumes all pin inputs synchronous to mclk; reset is the master reset, active high
//
// Overview of operation
// [RULE1] a low dll speed select turns this port's dll off.
// [RULE2] the host keeps dll speed select low whenever the port runs flow-through.
// [RULE3] read/write high reads the array, low writes it.
// [RULE4] ready goes low once dll lock and impedance calibration are both done; with the dll off the code waits for calibration only.
// [RULE5] the counter interrupt goes low one cycle before the unmasked bits reach all ones.
// [RULE6] at maximum count with wrap low, an increment clears the unmasked bits.
// [RULE7] at maximum count with wrap high, an increment loads the mirror value.
// [RULE8] a low retransmit reloads the counter with the initial burst address.
// [RULE9] a low mode strap selects flow-through, a high one pipelined.
// [RULE10] master reset is asynchronous and resets everything of the port at once; the code does not reset the array contents.
// [RULE11] the host applies a master reset after power-up before use.
// [RULE12] no echo clock is given in flow-through mode.
// [RULE13] after a large frequency change the host resets the dll and waits 1024 clocks.
// [RULE14] dll speed select resets only this dll; master reset resets every dll.
// [RULE15] counter control inputs are sampled on every rising clock edge.
// [RULE16] master reset clears the counter and releases the counter interrupt high.
`timescale 1ns/100ps
module dprpc_port (
   input  wire logic                          mclk,
   input  wire logic                          reset,
   input  wire logic                          dll_speed_select_n,
   input  wire logic                          flow_through_select,
   input  wire logic                          echo_clock_enable,
   input  wire logic                          port_enable,
   input  wire logic                          read_write,
   input  wire logic [dprpc_pkg::DATA_W-1:0]  write_data,
   input  wire logic [dprpc_pkg::CNT_W-1:0]   address_in,
   input  wire logic                          address_load_strobe,
   input  wire logic                          counter_enable_in,
   input  wire logic                          counter_reset_in,
   input  wire logic                          counter_or_mask_select,
   input  wire logic                          counter_wrap_select,
   input  wire logic                          burst_retransmit_n,
   output logic      [dprpc_pkg::DATA_W-1:0]  read_data,
   output logic                               port_ready_n,
   output logic                               counter_interrupt_n,
   output logic                               echo_clock_out,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [dprpc_pkg::WB_AW-1:0]   wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   output logic                               irq
);
   // ************************************
   // state
   // ************************************
   logic [dprpc_pkg::DATA_W-1:0] mem_ff [dprpc_pkg::MEM_DEPTH];
   logic [dprpc_pkg::DATA_W-1:0] rd_stage_ff, rdata_ff;
   logic [dprpc_pkg::CNT_W-1:0]  cnt_ff, mask_ff, mirror_ff, nxt_cnt;
   logic                         cnt_int_n_ff, strap_taken_ff, pipe_ff;
   logic [10:0]                  dll_cnt_ff;
   logic [6:0]                   zq_cnt_ff;
   logic                         ready_n_ff, echo_ff;
   logic [31:0]                  ctrl_ff, rdat_ff;
   logic [dprpc_pkg::IRQ_W-1:0]  irq_stat_ff, irq_en_ff, irq_set;
   logic                         ack_ff, irq_ff;
   dprpc_pkg::dprpc_cnt_op_t     op;

   // ************************************
   // counter control decode
   // ************************************
   wire at_max     = (cnt_ff & mask_ff) == mask_ff;
   wire [dprpc_pkg::CNT_W-1:0] inc_val = (cnt_ff & ~mask_ff)
                                        | ((cnt_ff + dprpc_pkg::CNT_W'(1)) & mask_ff);
   wire [dprpc_pkg::CNT_W-1:0] wrap_val = counter_wrap_select ? mirror_ff  // [RULE7]
                                                              : (cnt_ff & ~mask_ff); // [RULE6]
   // reset beats load beats retransmit beats increment
   assign op = counter_reset_in     ? dprpc_pkg::OP_RESET :  // [RULE15]
               address_load_strobe  ? dprpc_pkg::OP_LOAD  :
               !burst_retransmit_n  ? dprpc_pkg::OP_RETX  :
               counter_enable_in    ? dprpc_pkg::OP_INC   : dprpc_pkg::OP_HOLD;
   always_comb begin
      case (op)
         dprpc_pkg::OP_RESET: nxt_cnt = '0;
         dprpc_pkg::OP_LOAD:  nxt_cnt = counter_or_mask_select ? cnt_ff : address_in;
         dprpc_pkg::OP_RETX:  nxt_cnt = mirror_ff;                     // [RULE8]
         dprpc_pkg::OP_INC:   nxt_cnt = at_max ? wrap_val : inc_val;   // [RULE6] [RULE7]
         default:             nxt_cnt = cnt_ff;
      endcase
   end
   // low while the unmasked field sits one below all ones
   wire nxt_int_n = (nxt_cnt & mask_ff) != (mask_ff - dprpc_pkg::CNT_W'(1)); // [RULE5]

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin  // [RULE10] [RULE16]
         cnt_ff       <= '0;
         mirror_ff    <= '0;
         mask_ff      <= dprpc_pkg::MASK_RST;
         cnt_int_n_ff <= 1'b1;
      end else begin
         cnt_ff       <= nxt_cnt;
         cnt_int_n_ff <= nxt_int_n;
         if (op == dprpc_pkg::OP_LOAD && !counter_or_mask_select) mirror_ff <= address_in;
         if (op == dprpc_pkg::OP_LOAD && counter_or_mask_select) mask_ff <= address_in;
         if (op == dprpc_pkg::OP_RESET) mask_ff <= dprpc_pkg::MASK_RST;
      end
   end

   // ************************************
   // array access
   // ************************************
   wire do_write = port_enable && !read_write;  // [RULE3]
   wire do_read  = port_enable && read_write;
   always_ff @(posedge mclk) begin
      if (do_write) mem_ff[cnt_ff] <= write_data;
   end
   // flow-through answers one edge after the read, pipelined two
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_stage_ff <= '0;
         rdata_ff    <= '0;
      end else begin
         if (do_read) rd_stage_ff <= mem_ff[cnt_ff];
         if (!pipe_ff && do_read) rdata_ff <= mem_ff[cnt_ff];
         else if (pipe_ff) rdata_ff <= rd_stage_ff;
      end
   end

   // ************************************
   // mode strap, dll, calibration, echo
   // ************************************
   // strap caught at the first edge after release, never inside reset
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         strap_taken_ff <= 1'b0;
         pipe_ff        <= 1'b0;
      end else if (!strap_taken_ff) begin
         strap_taken_ff <= 1'b1;
         pipe_ff        <= flow_through_select;  // [RULE9]
      end
   end
   wire dll_on     = dll_speed_select_n && !ctrl_ff[dprpc_pkg::CTRL_DLL_OFF]; // [RULE1]
   wire dll_locked = dll_cnt_ff == 11'(dprpc_pkg::DLL_LOCK_CLOCKS);
   wire zq_done    = zq_cnt_ff == 7'(dprpc_pkg::ZQ_CAL_CYCLES);
   // a disabled dll needs no lock; only calibration gates ready then
   wire cal_done   = zq_done && (dll_locked || !dll_on);
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin  // [RULE14]
         dll_cnt_ff <= '0;
         zq_cnt_ff  <= '0;
         ready_n_ff <= 1'b1;
         echo_ff    <= 1'b0;
      end else begin
         if (!dll_on) dll_cnt_ff <= '0;  // [RULE14]
         else if (!dll_locked) dll_cnt_ff <= dll_cnt_ff + 11'(1);
         if (!zq_done) zq_cnt_ff <= zq_cnt_ff + 7'(1);
         ready_n_ff <= !cal_done;  // [RULE4]
         echo_ff    <= echo_clock_enable && pipe_ff && !echo_ff;  // [RULE12]
      end
   end

   // ************************************
   // wishbone slave and interrupt
   // ************************************
   wire       wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire       wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
   wire [31:0] status_w = {16'h0000, cnt_ff, 3'b000, dll_on, pipe_ff,
                           zq_done, dll_locked, !ready_n_ff};
   wire [31:0] rd_mux =
      (wb_adr_i == dprpc_pkg::REG_CTRL)     ? ctrl_ff :
      (wb_adr_i == dprpc_pkg::REG_STATUS)   ? status_w :
      (wb_adr_i == dprpc_pkg::REG_IRQ_STAT) ? {29'h0000_0000, irq_stat_ff} :
      (wb_adr_i == dprpc_pkg::REG_IRQ_EN)   ? {29'h0000_0000, irq_en_ff} : 32'h0000_0000;
   wire [dprpc_pkg::IRQ_W-1:0] irq_clr =
      (wb_wr && wb_adr_i == dprpc_pkg::REG_IRQ_CLR) ? wb_dat_i[dprpc_pkg::IRQ_W-1:0] : '0;
   assign irq_set = {op == dprpc_pkg::OP_INC && at_max,
                     !cal_done == 1'b0 && ready_n_ff,
                     !nxt_int_n && cnt_int_n_ff};
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ack_ff      <= 1'b0;
         rdat_ff     <= '0;
         ctrl_ff     <= dprpc_pkg::CTRL_RST;
         irq_en_ff   <= dprpc_pkg::IRQ_EN_RST;
         irq_stat_ff <= '0;
         irq_ff      <= 1'b0;
      end else begin
         ack_ff  <= wb_req;
         rdat_ff <= wb_req ? rd_mux : 32'h0000_0000;
         if (wb_wr && wb_adr_i == dprpc_pkg::REG_CTRL) ctrl_ff <= {31'h0, wb_dat_i[0]};
         if (wb_wr && wb_adr_i == dprpc_pkg::REG_IRQ_EN)
            irq_en_ff <= wb_dat_i[dprpc_pkg::IRQ_W-1:0];
         // a new event beats a clear in the same cycle
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
         irq_ff      <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
      end
   end

   assign read_data           = rdata_ff;
   assign port_ready_n        = ready_n_ff;
   assign counter_interrupt_n = cnt_int_n_ff;
   assign echo_clock_out      = echo_ff;
   assign wb_dat_o            = rdat_ff;
   assign wb_ack_o            = ack_ff;
   assign irq                 = irq_ff;

   // ************************************
   // assertions
   // ************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_dll_off_clears: assert property (!dll_speed_select_n |=> dll_cnt_ff == '0) // [RULE1]
      else $error("dll count kept while speed select low");
   a_dll_only_port: assert property (!dll_speed_select_n |=> !dll_locked) // [RULE14]
      else $error("dll still locked after speed select low");
   a_write_lands: assert property (do_write |=> mem_ff[$past(cnt_ff)] == $past(write_data)) // [RULE3]
      else $error("write data not stored");
   a_ft_read: assert property (!pipe_ff && strap_taken_ff && do_read ##1 !pipe_ff // [RULE3]
                               |-> rdata_ff == $past(mem_ff[cnt_ff]))
      else $error("flow-through read data wrong");
   a_ready_cause: assert property ($fell(port_ready_n) |-> $past(zq_done)) // [RULE4]
      else $error("ready low before calibration done");
   a_ready_lock: assert property (zq_done && dll_locked |=> !port_ready_n) // [RULE4]
      else $error("ready not given after lock");
   a_int_before_max: assert property (!counter_interrupt_n |-> // [RULE5]
                                      (cnt_ff & mask_ff) == mask_ff - 8'h01)
      else $error("counter interrupt at wrong count");
   a_wrap_zero: assert property (op == dprpc_pkg::OP_INC && at_max && !counter_wrap_select // [RULE6]
                                 |=> (cnt_ff & mask_ff) == '0)
      else $error("wrap did not clear counter");
   a_wrap_mirror: assert property (op == dprpc_pkg::OP_INC && at_max && counter_wrap_select // [RULE7]
                                   |=> cnt_ff == $past(mirror_ff))
      else $error("wrap did not load mirror");
   a_retx_reload: assert property (op == dprpc_pkg::OP_RETX |=> cnt_ff == $past(mirror_ff)) // [RULE8]
      else $error("retransmit did not reload");
   a_mode_strap: assert property ($rose(strap_taken_ff) |-> pipe_ff == $past(flow_through_select)) // [RULE9]
      else $error("mode strap not taken");
   a_reset_all: assert property (@(posedge mclk) disable iff (1'b0) reset |=> // [RULE10] [RULE16]
                                 cnt_ff == '0 && counter_interrupt_n && port_ready_n)
      else $error("reset did not clear port");
   a_no_echo_ft: assert property (strap_taken_ff && !pipe_ff |-> !echo_clock_out) // [RULE12]
      else $error("echo clock in flow-through");
   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");


   // ************************************
   // assertions: counter control
   // ************************************
   a_cnt_reset: assert property (op == dprpc_pkg::OP_RESET |=> cnt_ff == '0) // [RULE15]
      else $error("counter reset ignored");
   a_cnt_load: assert property (op == dprpc_pkg::OP_LOAD && !counter_or_mask_select // [RULE15]
                                |=> cnt_ff == $past(address_in))
      else $error("counter load ignored");
   a_mask_load: assert property (op == dprpc_pkg::OP_LOAD && counter_or_mask_select // [RULE15]
                                 |=> mask_ff == $past(address_in))
      else $error("mask load ignored");
   a_mirror_load: assert property (op == dprpc_pkg::OP_LOAD && !counter_or_mask_select // [RULE8]
                                   |=> mirror_ff == $past(address_in))
      else $error("mirror not loaded");
   a_cnt_hold: assert property (op == dprpc_pkg::OP_HOLD |=> $stable(cnt_ff)) // [RULE15]
      else $error("counter moved on hold");
   a_cnt_inc: assert property (op == dprpc_pkg::OP_INC && !at_max // [RULE15]
                               |=> (cnt_ff & mask_ff) == (($past(cnt_ff) + 8'h01) & mask_ff))
      else $error("counter increment wrong");

   // ************************************
   // assertions: wishbone and interrupt
   // ************************************
   a_ack_follows: assert property (wb_req |=> wb_ack_o)
      else $error("no ack after request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   // an event in the same cycle as its clear must survive
   a_irq_sticky: assert property (|irq_set |=> (irq_stat_ff & $past(irq_set)) == $past(irq_set))
      else $error("event lost against clear");
   a_irq_high: assert property (|(irq_stat_ff & irq_en_ff) && irq_clr == '0 |=> irq)
      else $error("irq low with enabled status");
   a_irq_cause: assert property (irq |-> |$past(irq_stat_ff | irq_set))
      else $error("irq high without status");

   // ************************************
   // assertions: mode, dll, ready, read path
   // ************************************
   a_strap_hold: assert property (strap_taken_ff |=> $stable(pipe_ff)) // [RULE9]
      else $error("mode changed after strap");
   a_ctrl_off: assert property (ctrl_ff[dprpc_pkg::CTRL_DLL_OFF] |=> dll_cnt_ff == '0) // [RULE1]
      else $error("dll runs while forced off");
   a_zq_ready: assert property (!port_ready_n |-> zq_done) // [RULE4]
      else $error("ready without calibration");
   a_rdata_hold: assert property (strap_taken_ff && !pipe_ff && !do_read // [RULE3]
                                  |=> $stable(read_data))
      else $error("read data moved without read");

   c_retx: cover property (op == dprpc_pkg::OP_RETX);
   c_wrap: cover property (op == dprpc_pkg::OP_INC && at_max);
   c_int: cover property ($fell(counter_interrupt_n));
   c_ready: cover property ($fell(port_ready_n));
   c_irq: cover property ($rose(irq));
endmodule

// File: sim/dprpc_host.sv
// host model: drives the pins of one memory port, one operation per clock edge
// assumes the port is strapped flow-through, so the dll stays off
`timescale 1ns/100ps
module dprpc_host (
   input  wire logic                         mclk,
   output logic                              dll_speed_select_n,
   output logic                              flow_through_select,
   output logic                              echo_clock_enable,
   output logic                              port_enable,
   output logic                              read_write,
   output logic [dprpc_pkg::DATA_W-1:0]      write_data,
   output logic [dprpc_pkg::CNT_W-1:0]       address_in,
   output logic                              address_load_strobe,
   output logic                              counter_enable_in,
   output logic                              counter_reset_in,
   output logic                              counter_or_mask_select,
   output logic                              counter_wrap_select,
   output logic                              burst_retransmit_n
);
   // ************************************
   // pin drive
   // ************************************
   initial begin
      dll_speed_select_n  = 1'b0;
      flow_through_select = 1'b0;
      echo_clock_enable   = 1'b1;
      op_pins(8'h04, 8'h00, 16'h0000);
   end
   // ctl: load, inc, cnt reset, mask sel, wrap, retx_n, enable, read
   task automatic op_pins(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d);
      {address_load_strobe, counter_enable_in, counter_reset_in} <= c[7:5];
      {counter_or_mask_select, counter_wrap_select} <= c[4:3];
      {burst_retransmit_n, port_enable, read_write} <= c[2:0];
      address_in <= a;
      write_data <= d;
   endtask
   // pins stand until the next call, so a caller must go idle explicitly
   task automatic op(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      op_pins(c, a, d);
   endtask
endmodule

// File: sim/dprpc_port_bench.sv
// self-checking bench: pin traffic through the host model, registers over wishbone
// assumes the package, the port and the host model are compiled before it
`timescale 1ns/100ps
module dprpc_port_bench;
   // ************************************
   // signals and helpers
   // ************************************
   localparam logic [7:0] IDL = 8'h04, LDA = 8'h84, INC = 8'h44, INW = 8'h4C;
   logic        mclk, reset, dll_speed_select_n, flow_through_select, echo_clock_enable;
   logic        port_enable, read_write, address_load_strobe, counter_enable_in;
   logic        counter_reset_in, counter_or_mask_select, counter_wrap_select;
   logic        burst_retransmit_n, port_ready_n, counter_interrupt_n, echo_clock_out;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, seen;
   logic [15:0] write_data, read_data;
   logic [7:0]  address_in, wb_adr_i, st;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, got, rnd;
   logic [7:0]  ta [6];
   logic [15:0] td [6];
   int          failures, num_checks, n;
   dprpc_port dut (.mclk, .reset, .dll_speed_select_n, .flow_through_select,
      .echo_clock_enable, .port_enable, .read_write, .write_data, .address_in,
      .address_load_strobe, .counter_enable_in, .counter_reset_in,
      .counter_or_mask_select, .counter_wrap_select, .burst_retransmit_n, .read_data,
      .port_ready_n, .counter_interrupt_n, .echo_clock_out, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq);
   dprpc_host host (.mclk, .dll_speed_select_n, .flow_through_select, .echo_clock_enable,
      .port_enable, .read_write, .write_data, .address_in, .address_load_strobe,
      .counter_enable_in, .counter_reset_in, .counter_or_mask_select,
      .counter_wrap_select, .burst_retransmit_n);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // full mask assumed: counter after k increments from a loaded start
   function automatic logic [7:0] cnt_after(input logic [7:0] m, input int k, input logic w);
      logic [7:0] c;
      c = m;
      for (int i = 0; i < k; i++) c = (c == 8'hFF) ? (w ? m : 8'h00) : c + 8'h01;
      return c;
   endfunction
   task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] a);
      num_checks++;
      if (a !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, e, a);
      end
   endtask
   task automatic chk_pin(input string what, input logic e, input logic a);
      chk_val(what, {31'h0, e}, {31'h0, a});
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      // look between edges so ack is settled, release at the edge that samples it
      do @(negedge mclk); while (wb_ack_o !== 1'b1 && ++n < 20);
      if (n >= 20) failures++;
      got = wb_dat_o;
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      @(posedge mclk);
   endtask
   task automatic chk_cnt(input logic [7:0] e);
      host.op(IDL, 8'h00, 16'h0000);
      wb(1'b0, dprpc_pkg::REG_STATUS, 32'h0000_0000);
      chk_val("counter", {24'h0, e}, {24'h0, got[15:8]});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ************************************
   // clock, watchdog, tests
   // ************************************
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      #160000;
      failures++;
      test_done();
   end
   initial begin
      {failures, num_checks, seen, reset, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
      reset = 1'b1;
      {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hF, 32'h0000_0000};
      rnd = 32'h017f_ce88;
      repeat (3) @(posedge mclk);
      chk_pin("ready_n in reset", 1'b1, port_ready_n);
      chk_pin("cnt_int_n in reset", 1'b1, counter_interrupt_n);
      reset <= 1'b0;
      repeat (10) @(posedge mclk);
      chk_pin("ready_n early", 1'b1, port_ready_n);
      for (n = 0; port_ready_n !== 1'b0 && n < 200; n++) begin
         @(posedge mclk);
         seen = seen | echo_clock_out;
      end
      chk_pin("ready_n", 1'b0, port_ready_n);
      chk_pin("echo in flow-through", 1'b0, seen);
      wb(1'b0, dprpc_pkg::REG_STATUS, 32'h0000_0000);
      chk_pin("pipelined", 1'b0, got[dprpc_pkg::ST_PIPE]);
      chk_pin("dll on", 1'b0, got[dprpc_pkg::ST_DLL_ON]);
      $display("test ready done");
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         ta[i] = {i[3:0], rnd[3:0]};
         td[i] = rnd[31:16];
         host.op(LDA, ta[i], 16'h0000);
         host.op(8'h06, 8'h00, td[i]);
      end
      for (int i = 0; i < 6; i++) begin
         host.op(LDA, ta[i], 16'h0000);
         host.op(8'h07, 8'h00, 16'h0000);
         host.op(IDL, 8'h00, 16'h0000);
         @(posedge mclk);
         chk_val("read_data", {16'h0, td[i]}, {16'h0, read_data});
      end
      $display("test array done");
      for (int w = 0; w < 2; w++) begin
         host.op(LDA, 8'hF0, 16'h0000);
         repeat (14) host.op(INC, 8'h00, 16'h0000);
         host.op(IDL, 8'h00, 16'h0000);
         for (n = 0; counter_interrupt_n !== 1'b0 && n < 4; n++) @(posedge mclk);
         chk_pin("cnt_int_n at FE", 1'b0, counter_interrupt_n);
         host.op(INC, 8'h00, 16'h0000);
         host.op(w[0] ? INW : INC, 8'h00, 16'h0000);
         chk_cnt(cnt_after(8'hF0, 16, w[0]));
         chk_pin("cnt_int_n after wrap", 1'b1, counter_interrupt_n);
      end
      st = rnd[7:0] & 8'h7F;
      host.op(LDA, st, 16'h0000);
      repeat (3) host.op(INC, 8'h00, 16'h0000);
      host.op(8'h00, 8'h00, 16'h0000);
      chk_cnt(st);
      $display("test counter done");
      wb(1'b0, 8'h20, 32'h0000_0000);
      chk_val("unmapped", 32'h0000_0000, got);
      wb(1'b0, dprpc_pkg::REG_IRQ_STAT, 32'h0000_0000);
      chk_val("irq status", 32'h0000_0007, got);
      chk_pin("irq masked", 1'b0, irq);
      wb(1'b1, dprpc_pkg::REG_IRQ_EN, 32'h0000_0002);
      repeat (2) @(posedge mclk);
      chk_pin("irq enabled", 1'b1, irq);
      wb(1'b1, dprpc_pkg::REG_IRQ_CLR, 32'h0000_0002);
      repeat (2) @(posedge mclk);
      chk_pin("irq cleared", 1'b0, irq);
      wb(1'b0, dprpc_pkg::REG_IRQ_STAT, 32'h0000_0000);
      chk_val("irq status cleared", 32'h0000_0005, got);
      $display("test registers done");
      host.op(LDA, 8'h55, 16'h0000);
      host.op(IDL, 8'h00, 16'h0000);
      reset <= 1'b1;
      repeat (3) @(posedge mclk);
      chk_pin("ready_n mid reset", 1'b1, port_ready_n);
      chk_pin("cnt_int_n mid reset", 1'b1, counter_interrupt_n);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      chk_cnt(8'h00);
      $display("test reset done");
      test_done();
   end
endmodule
